// [bench/keypad_menu_checker.sv]
`timescale 1ns/1ns
module keypad_menu_checker
  import keypad_menu_pkg::*;
(
  input wire logic    mclk_i,
  input wire logic    sys_rst_i,
  input wire logic    ce_i,
  input wire drive_s  drive_i,
  input wire led_s    led_o,
  input wire screen_s screen_o,
  input wire cmd_s    cmd_o
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_fault_led: assert property (
    ce_i |=> led_o.fault == $past(drive_i.fault | drive_i.alarm)) else $error("fault led wrong");
  a_dir_steady: assert property (
    ce_i && drive_i.running && !drive_i.stopping |=> led_o.forward != led_o.backward
    && led_o.backward == $past(drive_i.reverse)) else $error("direction led wrong");
  a_run_pulse: assert property (
    cmd_o.run |=> !cmd_o.run) else $error("run command too long");
  a_tune_start: assert property (
    cmd_o.tune_start |-> ##[0:2] screen_o.menu == ST_TUNING) else $error("tuning did not start");
  a_tune_label: assert property (
    screen_o.menu == ST_TUNING && $past(screen_o.menu) == ST_TUNING |-> $stable(screen_o.label))
    else $error("label changed in tuning");
  a_tune_banner: assert property (
    screen_o.menu == ST_TUNING |-> led_o.run && screen_o.banner) else $error("tuning banner missing");
  a_tune_abort: assert property (
    cmd_o.tune_abort |-> ##[0:2] screen_o.menu == ST_TMENU) else $error("abort left wrong menu");
  a_tfail_coast: assert property (
    screen_o.menu == ST_TFAIL |-> cmd_o.coast && screen_o.fault_msg && screen_o.incomplete)
    else $error("tuning fault screen wrong");
  a_done_write: assert property (
    cmd_o.motor_wr |-> ##[0:2] screen_o.menu == ST_TDONE) else $error("motor write outside done");
  a_done_dark: assert property (
    screen_o.menu == ST_TDONE |-> !led_o.run) else $error("run led lit after tuning");
endmodule : keypad_menu_checker

// [bench/keypad_operator.sv]
`timescale 1ns/1ns
module keypad_operator
  import keypad_menu_pkg::*;
(
  input  wire logic mclk_i,
  input  wire key_s want_i,
  output key_s      keys_o
);
  // -----------------------
  // Contacts bounce on edges
  // -----------------------
  key_s       settled_ff = '0;
  logic [2:0] age_ff     = 3'h0;
  // Short glitches a debouncer must swallow
  always @(posedge mclk_i) begin
    age_ff <= (want_i == settled_ff) ? 3'h0 : age_ff + 3'h1;
    if (age_ff == 3'h5) begin
      settled_ff <= want_i;
    end
    keys_o <= (age_ff[0] && want_i != settled_ff) ? want_i : settled_ff;
  end
endmodule : keypad_operator

// [bench/test_keypad_menu_controller.sv]
`timescale 1ns/1ns
module test_keypad_menu_controller;
  import keypad_menu_pkg::*;
  // -----------------
  // Bench and wiring
  // -----------------
  localparam logic [7:0] K_RUN = 8'h80, K_STOP = 8'h40, K_UP = 8'h20, K_DN = 8'h10;
  localparam logic [7:0] K_DIR = 8'h08, K_SCR = 8'h04, K_SH = 8'h02, K_ENT = 8'h01;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  key_s        want, keys;
  drive_s      drv;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic        wstb, rstb;
  led_s        led;
  screen_s     scr;
  cmd_s        cmd;
  logic [10:0] paddr;
  logic [15:0] ref_v;
  logic        ce = 1'b1, pwr;
  logic [15:0] prd = 16'h0000, pwd;
  logic [1:0]  dig;
  int          clrs = 0, pwrs = 0;
  int          err_total = 0, checked = 0, cyc = 0, runs = 0, stops = 0, aborts = 0, mwr = 0, rv, s, f, t;
  always #25 mclk_i = ~mclk_i;
  keypad_operator i_keypad_operator (.mclk_i(mclk_i), .want_i(want), .keys_o(keys));
  keypad_menu_controller #(.DEBOUNCE_P(4), .HOLD_P(40), .REPEAT_P(10), .BLINK_P(8), .EDIT_TO_P(200))
    i_keypad_menu_controller (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .keys_i(keys),
    .drive_i(drv), .param_rd_i(prd), .addr_i(addr), .wdata_i(wdata), .wstb_i(wstb), .rstb_i(rstb),
    .rdata_o(rdata), .led_o(led), .screen_o(scr), .cmd_o(cmd), .param_addr_o(paddr), .param_wr_o(pwr),
    .param_wdata_o(pwd), .ref_o(ref_v), .digit_o(dig));
  always @(posedge mclk_i) begin
    cyc++;
    if (cmd.run === 1'b1) runs++;
    if (cmd.stop === 1'b1) stops++;
    if (cmd.tune_abort === 1'b1) aborts++;
    if (cmd.motor_wr === 1'b1) mwr++;
    if (cmd.fault_clear === 1'b1) clrs++;
    if (pwr === 1'b1) pwrs++;
    if (cyc == 6000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick
  task automatic press(input logic [7:0] k);
    want <= k;
    tick(20);
    want <= '0;
    tick(20);
  endtask : press
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wstb <= 1'b1;
    tick(1);
    wstb <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    addr <= a;
    rstb <= 1'b1;
    tick(1);
    rstb <= 1'b0;
    #1 d = rdata;
    tick(1);
  endtask : rd
  task automatic final_report();
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    want = '0;
    drv = '0;
    addr = '0;
    wdata = '0;
    wstb = 1'b0;
    rstb = 1'b0;
    rv = $urandom(80);
    tick(20);
    sys_rst_i <= 1'b0;
    tick(2);
    chk(scr.menu, ST_MONITOR);
    repeat (8) begin
      s = $urandom % 3;
      f = $urandom % 3;
      drv <= drive_s'(7'($urandom));
      wr(ADDR_CTRL, {25'h0, METH_VECTOR, 2'(f), 2'(s)});
      tick(3);
      chk(led.fault, drv.fault | drv.alarm);
      chk(led.run_source, s != 0);
      chk(led.ref_source, f != 0);
    end
    // Stopping forward: a 16-cycle window of the blink holds 8 lit cycles
    drv <= drive_s'(7'h10);
    tick(3);
    f = 0;
    repeat (16) begin
      tick(1);
      f += led.forward;
    end
    chk(f, 8);
    chk(led.backward, 0);
    ce <= 1'b0;
    drv <= drive_s'(7'h08);
    tick(4);
    chk(led.fault, 0);
    ce <= 1'b1;
    tick(3);
    chk(led.fault, 1);
    drv <= '0;
    press(K_SCR);
    chk(scr.menu, ST_GROUP);
    press(K_SCR);
    chk(scr.menu, ST_MONITOR);
    wr(ADDR_REF_LO, 32'h10);
    wr(ADDR_REF_HI, 32'h20);
    wr(ADDR_REF, 32'h10);
    rv = (16 - 1 < 16) ? 32 : 15;
    press(K_DN);
    press(K_DN);
    chk(ref_v, rv);
    press(K_ENT);
    rd(ADDR_REF);
    chk(d, rv);
    press(K_UP);
    press(K_UP);
    chk(ref_v, (rv + 1 > 32) ? 16 : rv + 1);
    tick(220);
    chk(scr.menu, ST_MONITOR);
    chk(ref_v, rv);
    // Held key: one press step plus four repeats, first step wraps
    press(K_UP);
    want <= K_UP;
    tick(75);
    want <= '0;
    tick(20);
    chk(ref_v, 20);
    press(K_ENT);
    press(K_DIR);
    chk(cmd.reverse, 1);
    press(K_DIR);
    chk(cmd.reverse, 0);
    press(K_RUN);
    press(K_STOP);
    chk(runs, 1);
    chk(stops, 1);
    press(K_SCR);
    repeat (6) press(K_DN);
    chk(paddr[10:6], GRP_TUNE);
    drv.alarm <= 1'b1;
    press(K_UP);
    press(K_DN);
    chk(paddr[10:6], GRP_TUNE - 5'h01);
    drv.alarm <= 1'b0;
    press(K_UP);
    press(K_ENT);
    chk(scr.menu, ST_TMENU);
    wr(ADDR_CTRL, 32'h0);
    press(K_DN);
    chk(paddr[5:0], TIDX_LAST_VF);
    press(K_UP);
    chk(paddr[5:0], 0);
    wr(ADDR_CTRL, {25'h0, METH_VECTOR, 4'h0});
    // Nameplate fields come first, then the run key
    for (t = 1; t <= 6; t++) begin
      press(K_UP);
      prd <= 16'($urandom);
      press(K_ENT);
      press(K_SH);
      chk(dig, 1);
      press(K_UP);
      press(K_ENT);
      chk(paddr[5:0], t);
      chk(pwd, (prd > 16'hFFF5) ? 16'hFFFF : prd + 16'h000A);
    end
    rd(ADDR_STATUS);
    chk(d[14:8], NAMEPLATE_ALL);
    for (int i = 0; i < 4; i++) begin
      t = (i == 3) ? 4 : i;
      wr(ADDR_CTRL, {22'h0, 3'(t), METH_VECTOR, 4'h0});
      press(K_RUN);
      chk(scr.menu, ST_TUNING);
      chk(scr.label, (t == 4) ? 4 : t + 1);
      chk(led.run, 1);
      if (i == 1) begin
        drv.tune_fault <= 1'b1;
        tick(2);
        drv.tune_fault <= 1'b0;
        tick(6);
        chk(scr.menu, ST_TFAIL);
        press(K_SH);
        chk(scr.menu, ST_TMENU);
      end else if (i == 3) begin
        drv.tune_done <= 1'b1;
        tick(2);
        drv.tune_done <= 1'b0;
        tick(6);
        chk(mwr, 1);
        chk(led.run, 0);
        press(K_SCR);
        chk(scr.menu, ST_MONITOR);
      end else begin
        press(K_STOP);
        chk(scr.menu, ST_TMENU);
      end
    end
    chk(aborts, 2);
    chk(pwrs, 6);
    chk(clrs, 1);
    final_report();
  end
endmodule : test_keypad_menu_controller
bind keypad_menu_controller keypad_menu_checker i_keypad_menu_checker (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .ce_i(ce_i), .drive_i(drive_i), .led_o(led_o), .screen_o(screen_o), .cmd_o(cmd_o));

// [hw/keypad_menu_controller.sv]
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ns
module keypad_menu_controller
  import keypad_menu_pkg::*;
#(
  parameter int unsigned DEBOUNCE_P = DEBOUNCE_CYC,
  parameter int unsigned HOLD_P     = HOLD_CYC,
  parameter int unsigned REPEAT_P   = REPEAT_CYC,
  parameter int unsigned BLINK_P    = BLINK_CYC,
  parameter int unsigned EDIT_TO_P  = EDIT_TO_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  input  wire key_s        keys_i,
  input  wire drive_s      drive_i,
  input  wire logic [15:0] param_rd_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wstb_i,
  input  wire logic        rstb_i,
  output logic      [31:0] rdata_o,
  output led_s             led_o,
  output screen_s          screen_o,
  output cmd_s             cmd_o,
  output logic      [10:0] param_addr_o,
  output logic             param_wr_o,
  output logic      [15:0] param_wdata_o,
  output logic      [15:0] ref_o,
  output logic      [1:0]  digit_o
);
  // ----------------------------------------------------------------
  // Key conditioning
  // ----------------------------------------------------------------
  logic [7:0]       key_raw;
  logic [7:0]       sync1_ff;
  logic [7:0]       sync2_ff;
  logic [7:0]       stable_ff;
  logic [7:0]       press_ff;
  logic [CNT_W-1:0] db_cnt_ff [8];

  assign key_raw = keys_i;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else if (ce_i) begin
      sync1_ff <= key_raw;
      sync2_ff <= sync1_ff;
    end
  end

  // Per-key filter; a bounce restarts the settle count
  for (genvar k = 0; k < 8; k++) begin : g_key
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        db_cnt_ff[k] <= '0;
        stable_ff[k] <= 1'b0;
        press_ff[k]  <= 1'b0;
      end else if (ce_i) begin
        press_ff[k] <= 1'b0;
        if (sync2_ff[k] == stable_ff[k]) begin
          db_cnt_ff[k] <= '0;
        end else if (db_cnt_ff[k] == CNT_W'(DEBOUNCE_P - 1)) begin
          db_cnt_ff[k] <= '0;
          stable_ff[k] <= sync2_ff[k];
          press_ff[k]  <= sync2_ff[k];
        end else begin
          db_cnt_ff[k] <= db_cnt_ff[k] + CNT_W'(1);
        end
      end
    end
  end

  key_s press;
  key_s held;
  assign press = press_ff;
  assign held  = stable_ff;

  // ----------------------------------------------------------------
  // Auto-repeat and blink
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] hold_cnt_ff;
  logic             rep_ff;
  logic [CNT_W-1:0] blink_cnt_ff;
  logic             blink_ff;
  logic             inc_ev;
  logic             dec_ev;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_cnt_ff <= '0;
      rep_ff      <= 1'b0;
    end else if (ce_i) begin
      rep_ff <= 1'b0;
      if (held.up == held.down) begin
        hold_cnt_ff <= '0;
      end else if (hold_cnt_ff == CNT_W'(HOLD_P - 1)) begin
        rep_ff      <= 1'b1;
        hold_cnt_ff <= CNT_W'(HOLD_P - REPEAT_P);
      end else begin
        hold_cnt_ff <= hold_cnt_ff + CNT_W'(1);
      end
    end
  end

  assign inc_ev = press.up | (rep_ff & held.up);
  assign dec_ev = press.down | (rep_ff & held.down);

  // One free-running generator keeps all flashing LEDs in phase
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      blink_cnt_ff <= '0;
      blink_ff     <= 1'b0;
    end else if (ce_i) begin
      if (blink_cnt_ff == CNT_W'(BLINK_P - 1)) begin
        blink_cnt_ff <= '0;
        blink_ff     <= ~blink_ff;
      end else begin
        blink_cnt_ff <= blink_cnt_ff + CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [1:0]  run_src_ff;
  logic [1:0]  ref_src_ff;
  logic [2:0]  method_ff;
  logic [2:0]  tune_type_ff;
  logic [15:0] ref_lo_ff;
  logic [15:0] ref_hi_ff;
  logic [15:0] ref_ff;
  logic [15:0] edit_ff;
  logic [15:0] step;
  logic [1:0]  digit_ff;
  menu_e       state_ff;
  logic [6:0]  plate_ff;
  logic [4:0]  grp_ff;
  logic [5:0]  idx_ff;
  logic        commit;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_src_ff   <= SRC_KEYPAD;
      ref_src_ff   <= SRC_KEYPAD;
      method_ff    <= 3'h0;
      tune_type_ff <= 3'h0;
      ref_lo_ff    <= REF_LO_RST;
      ref_hi_ff    <= REF_HI_RST;
    end else if (ce_i) begin
      if (wstb_i && addr_i == ADDR_CTRL) begin
        run_src_ff   <= wdata_i[CTRL_RUN_LSB +: 2];
        ref_src_ff   <= wdata_i[CTRL_REF_LSB +: 2];
        method_ff    <= wdata_i[CTRL_METH_LSB +: 3];
        tune_type_ff <= wdata_i[CTRL_TYPE_LSB +: 3];
      end else if (commit && grp_ff == GRP_TUNE && idx_ff == 6'h00) begin
        tune_type_ff <= edit_ff[2:0];
      end
      if (wstb_i && addr_i == ADDR_REF_LO) begin
        ref_lo_ff <= wdata_i[15:0];
      end
      if (wstb_i && addr_i == ADDR_REF_HI) begin
        ref_hi_ff <= wdata_i[15:0];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= '0;
      if (rstb_i) begin
        unique case (addr_i)
          ADDR_CTRL:   rdata_o <= {22'h0, tune_type_ff, method_ff, ref_src_ff, run_src_ff};
          ADDR_REF_LO: rdata_o <= {16'h0, ref_lo_ff};
          ADDR_REF_HI: rdata_o <= {16'h0, ref_hi_ff};
          ADDR_REF:    rdata_o <= {16'h0, ref_ff};
          ADDR_STATUS: rdata_o <= {17'h0, plate_ff, digit_ff, 2'h0, state_ff};
          default:     rdata_o <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Menu machine
  // ----------------------------------------------------------------
  logic             tune_hidden;
  logic [5:0]       tidx_last;
  logic [CNT_W-1:0] to_cnt_ff;
  logic             timeout;
  logic             editing;

  assign tune_hidden = drive_i.running | drive_i.fault | drive_i.alarm;
  assign tidx_last   = (method_ff >= METH_VECTOR) ? TIDX_LAST_ALL : TIDX_LAST_VF;
  assign editing     = (state_ff == ST_EDIT) || (state_ff == ST_REFEDIT);
  assign timeout     = editing && to_cnt_ff == CNT_W'(EDIT_TO_P - 1);
  assign commit      = (state_ff == ST_EDIT) && press.enter && !timeout;

  always_comb begin
    unique case (digit_ff)
      2'h0: step = 16'h0001;
      2'h1: step = 16'h000A;
      2'h2: step = 16'h0064;
      2'h3: step = 16'h03E8;
    endcase
  end

  // Any key press or auto-repeat step restarts the edit timeout
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      to_cnt_ff <= '0;
    end else if (ce_i) begin
      if (!editing || press != '0 || rep_ff) begin
        to_cnt_ff <= '0;
      end else if (!timeout) begin
        to_cnt_ff <= to_cnt_ff + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= ST_MONITOR;
      grp_ff   <= 5'h00;
      idx_ff   <= 6'h00;
    end else if (ce_i) begin
      unique case (state_ff)
        ST_MONITOR: begin
          if (press.screen) begin
            state_ff <= ST_GROUP;
          end else if (inc_ev || dec_ev) begin
            state_ff <= ST_REFEDIT;
          end
        end
        ST_GROUP: begin
          if (press.screen) begin
            state_ff <= ST_MONITOR;
          end else if (press.enter) begin
            idx_ff   <= 6'h00;
            state_ff <= (grp_ff == GRP_TUNE) ? ST_TMENU : ST_PLIST;
          end else if (inc_ev) begin
            if (grp_ff == GRP_LAST) begin
              grp_ff <= 5'h00;
            end else if (grp_ff + 5'h01 == GRP_TUNE && tune_hidden) begin
              grp_ff <= GRP_TUNE + 5'h01;
            end else begin
              grp_ff <= grp_ff + 5'h01;
            end
          end else if (dec_ev) begin
            if (grp_ff == 5'h00) begin
              grp_ff <= GRP_LAST;
            end else if (grp_ff - 5'h01 == GRP_TUNE && tune_hidden) begin
              grp_ff <= GRP_TUNE - 5'h01;
            end else begin
              grp_ff <= grp_ff - 5'h01;
            end
          end
        end
        ST_PLIST: begin
          if (press.screen) begin
            state_ff <= ST_MONITOR;
          end else if (press.enter) begin
            state_ff <= ST_EDIT;
          end else if (inc_ev) begin
            idx_ff <= idx_ff + 6'h01;
          end else if (dec_ev) begin
            idx_ff <= idx_ff - 6'h01;
          end
        end
        ST_TMENU: begin
          if (press.screen) begin
            state_ff <= ST_MONITOR;
          end else if (press.run && plate_ff == NAMEPLATE_ALL && !tune_hidden) begin
            state_ff <= ST_TUNING;
          end else if (press.enter) begin
            state_ff <= ST_EDIT;
          end else if (inc_ev) begin
            idx_ff <= (idx_ff >= tidx_last) ? 6'h00 : idx_ff + 6'h01;
          end else if (dec_ev) begin
            idx_ff <= (idx_ff == 6'h00) ? tidx_last : idx_ff - 6'h01;
          end
        end
        ST_EDIT: begin
          if (timeout) begin
            state_ff <= ST_MONITOR;
          end else if (press.enter) begin
            state_ff <= (grp_ff == GRP_TUNE) ? ST_TMENU : ST_PLIST;
          end
        end
        ST_REFEDIT: begin
          if (timeout || press.enter) begin
            state_ff <= ST_MONITOR;
          end
        end
        ST_TUNING: begin
          if (press.stop) begin
            state_ff <= ST_TMENU;
          end else if (drive_i.tune_fault) begin
            state_ff <= ST_TFAIL;
          end else if (drive_i.tune_done) begin
            state_ff <= ST_TDONE;
          end
        end
        ST_TFAIL: begin
          if (press.shift) begin
            state_ff <= ST_TMENU;
          end
        end
        ST_TDONE: begin
          if (press.screen) begin
            state_ff <= ST_MONITOR;
          end
        end
        default: state_ff <= ST_MONITOR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Edit values
  // ----------------------------------------------------------------
  // Plain parameters saturate; only the reference wraps
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      edit_ff  <= 16'h0000;
      digit_ff <= 2'h0;
    end else if (ce_i) begin
      if ((state_ff == ST_PLIST || state_ff == ST_TMENU) && press.enter) begin
        edit_ff  <= param_rd_i;
        digit_ff <= 2'h0;
      end else if (state_ff == ST_MONITOR && (inc_ev || dec_ev)) begin
        edit_ff  <= ref_ff;
        digit_ff <= 2'h0;
      end else if (editing) begin
        if (press.shift) begin
          digit_ff <= (digit_ff == DIGIT_LAST) ? 2'h0 : digit_ff + 2'h1;
        end else if (inc_ev) begin
          if (state_ff == ST_REFEDIT) begin
            edit_ff <= ({1'b0, edit_ff} + {1'b0, step} > {1'b0, ref_hi_ff}) ?
                       ref_lo_ff : edit_ff + step;
          end else begin
            edit_ff <= ({1'b0, edit_ff} + {1'b0, step} > 17'h0FFFF) ? 16'hFFFF : edit_ff + step;
          end
        end else if (dec_ev) begin
          if (state_ff == ST_REFEDIT) begin
            edit_ff <= ({1'b0, edit_ff} < {1'b0, ref_lo_ff} + {1'b0, step}) ?
                       ref_hi_ff : edit_ff - step;
          end else begin
            edit_ff <= (edit_ff < step) ? 16'h0000 : edit_ff - step;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ref_ff <= REF_RST;
    end else if (ce_i) begin
      if (wstb_i && addr_i == ADDR_REF) begin
        ref_ff <= wdata_i[15:0];
      end else if (state_ff == ST_REFEDIT && press.enter && !timeout) begin
        ref_ff <= edit_ff;
      end
    end
  end

  // Nameplate entries 17-01..17-06 must each be saved once
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      plate_ff <= 7'h00;
    end else if (ce_i) begin
      if (commit && grp_ff == GRP_TUNE && idx_ff <= 6'h06) begin
        plate_ff[idx_ff[2:0]] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic   dir_rev_ff;
  label_e label;

  always_comb begin
    unique case (tune_type_ff)
      3'h0:    label = LBL_ROTATING;
      3'h1:    label = LBL_STATIONARY;
      3'h2:    label = LBL_WINDING;
      3'h4:    label = LBL_LOOP;
      default: label = LBL_NONE;
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dir_rev_ff <= 1'b0;
    end else if (ce_i && press.dir) begin
      dir_rev_ff <= ~dir_rev_ff;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_o         <= '0;
      param_wr_o    <= 1'b0;
      param_wdata_o <= 16'h0000;
      param_addr_o  <= 11'h000;
    end else if (ce_i) begin
      cmd_o.run         <= press.run && state_ff != ST_TMENU && state_ff != ST_TUNING;
      cmd_o.stop        <= press.stop;
      cmd_o.reverse     <= dir_rev_ff;
      cmd_o.fault_clear <= press.shift && (drive_i.fault || state_ff == ST_TFAIL);
      cmd_o.tune_start  <= state_ff == ST_TMENU && press.run && plate_ff == NAMEPLATE_ALL && !tune_hidden;
      cmd_o.tune_abort  <= state_ff == ST_TUNING && press.stop;
      cmd_o.coast       <= state_ff == ST_TFAIL;
      cmd_o.motor_wr    <= state_ff == ST_TUNING && !press.stop && !drive_i.tune_fault
                           && drive_i.tune_done;
      param_wr_o        <= commit;
      param_wdata_o     <= edit_ff;
      param_addr_o      <= {grp_ff, idx_ff};
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      led_o    <= '0;
      screen_o <= '{menu: ST_MONITOR, label: LBL_NONE, default: 1'b0};
      ref_o    <= REF_RST;
      digit_o  <= 2'h0;
    end else if (ce_i) begin
      led_o.fault      <= drive_i.fault | drive_i.alarm;
      led_o.forward    <= !drive_i.reverse && (drive_i.stopping ? blink_ff : drive_i.running);
      led_o.backward   <= drive_i.reverse && (drive_i.stopping ? blink_ff : drive_i.running);
      led_o.run_source <= run_src_ff == SRC_TERMINAL || run_src_ff == SRC_SERIAL;
      led_o.ref_source <= ref_src_ff == SRC_TERMINAL || ref_src_ff == SRC_SERIAL;
      unique case (state_ff)
        ST_TUNING: led_o.run <= 1'b1;
        ST_TFAIL:  led_o.run <= blink_ff;
        ST_TDONE:  led_o.run <= 1'b0;
        default:   led_o.run <= drive_i.stopping ? blink_ff : drive_i.running;
      endcase
      screen_o.menu       <= state_ff;
      screen_o.label      <= (state_ff == ST_TUNING) ? label : LBL_NONE;
      screen_o.banner     <= state_ff == ST_TUNING;
      screen_o.fault_msg  <= state_ff == ST_TFAIL;
      screen_o.incomplete <= state_ff == ST_TFAIL;
      ref_o               <= editing ? edit_ff : ref_ff;
      digit_o             <= digit_ff;
    end
  end
endmodule : keypad_menu_controller

// [include/keypad_menu_pkg.sv]
package keypad_menu_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned DEBOUNCE_MS   = 20;
  localparam int unsigned HOLD_MS       = 500;
  localparam int unsigned REPEAT_MS     = 100;
  localparam int unsigned BLINK_MS      = 250;
  localparam int unsigned EDIT_TO_MS    = 5000;
  localparam int unsigned DEBOUNCE_CYC  = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned HOLD_CYC      = CLK_HZ / 1000 * HOLD_MS;
  localparam int unsigned REPEAT_CYC    = CLK_HZ / 1000 * REPEAT_MS;
  localparam int unsigned BLINK_CYC     = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned EDIT_TO_CYC   = CLK_HZ / 1000 * EDIT_TO_MS;
  localparam int unsigned CNT_W         = 27;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_REF_LO   = 8'h04;
  localparam logic [7:0]  ADDR_REF_HI   = 8'h08;
  localparam logic [7:0]  ADDR_REF      = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS   = 8'h10;
  localparam int unsigned CTRL_RUN_LSB  = 0;
  localparam int unsigned CTRL_REF_LSB  = 2;
  localparam int unsigned CTRL_METH_LSB = 4;
  localparam int unsigned CTRL_TYPE_LSB = 7;
  localparam logic [15:0] REF_LO_RST    = 16'h0000;
  localparam logic [15:0] REF_HI_RST    = 16'h1770;
  localparam logic [15:0] REF_RST       = 16'h0000;
  localparam logic [1:0]  SRC_KEYPAD    = 2'h0;
  localparam logic [1:0]  SRC_TERMINAL  = 2'h1;
  localparam logic [1:0]  SRC_SERIAL    = 2'h2;
  // ----------------------------------------------------------------
  // Menu constants
  // ----------------------------------------------------------------
  localparam logic [4:0]  GRP_LAST      = 5'h16;
  localparam logic [4:0]  GRP_TUNE      = 5'h11;
  localparam logic [5:0]  TIDX_LAST_VF  = 6'h02;
  localparam logic [5:0]  TIDX_LAST_ALL = 6'h06;
  localparam logic [6:0]  NAMEPLATE_ALL = 7'h7E;
  localparam logic [2:0]  METH_VECTOR   = 3'h2;
  localparam logic [1:0]  DIGIT_LAST    = 2'h3;

  typedef enum logic [3:0] {
    ST_MONITOR = 4'h0, ST_GROUP  = 4'h1, ST_PLIST = 4'h3, ST_EDIT = 4'h2,
    ST_REFEDIT = 4'h6, ST_TMENU  = 4'h7, ST_TUNING = 4'h5, ST_TFAIL = 4'h4,
    ST_TDONE   = 4'hC
  } menu_e;

  typedef enum logic [2:0] {
    LBL_NONE = 3'h0, LBL_ROTATING = 3'h1, LBL_STATIONARY = 3'h2,
    LBL_WINDING = 3'h3, LBL_LOOP = 3'h4
  } label_e;

  typedef struct packed {
    logic run, stop, up, down, dir, screen, shift, enter;
  } key_s;

  typedef struct packed {
    logic running, reverse, stopping, fault, alarm, tune_fault, tune_done;
  } drive_s;

  typedef struct packed {
    logic fault, forward, backward, run, run_source, ref_source;
  } led_s;

  typedef struct packed {
    menu_e  menu;
    label_e label;
    logic   banner, fault_msg, incomplete;
  } screen_s;

  typedef struct packed {
    logic run, stop, reverse, fault_clear, tune_start, tune_abort, coast, motor_wr;
  } cmd_s;
endpackage : keypad_menu_pkg
